// ==== rtl/rwc_top.sv ====
/*
 Reset and watchdog controller top: merges reset sources, stretches the
 internal reset, runs the watchdog and its guarded control word, and offers
 an APB slave. Assumes fuses are static and pins are asynchronous.
*/
// Chosen here: the placing of the registers and the APB interface to the registers.
// How it works
// [RL1] Core restarts from vector after reset
// [RL2] Port reset follows sources with no clock
// [RL3] Internal reset held until stretch expires
// [RL4] Five sources merged into one reset
// [RL5] Reset pin low past minimum resets
// [RL6] Pin release starts the stretch counter
// [RL7] Scan reset bit holds reset while set
// [RL8] Power-on asserts at once, release stretches
// [RL9] Enabled undervolt resets, release then stretches
// [RL10] Undervolt counts only past minimum duration
// [RL11] Watchdog reset pulse one cycle, then stretch
// [RL12] Bandgap on for detector, comparator, converter
// [RL13] Watchdog counts its own oscillator ticks
// [RL14] Restart clears watchdog before time-out
// [RL15] Prescaler selects 16 ms to 8 s
// [RL16] Interrupt mode raises wake-capable interrupt
// [RL17] Reset mode expiry resets the device
// [RL18] Combined mode: interrupt first, then reset
// [RL19] Always-on fuse forces reset mode
// [RL20] Opening write sets change and reset enables
// [RL21] Guarded changes only inside four-cycle window
// [RL22] Change enable clears after four cycles
// [RL23] Reset enable stuck while reset flag set
// [RL24] Interrupt flag: vector or write one clears
// [RL25] Source flags set; zero or power-on clears
`timescale 1ns/10ps
`default_nettype none
module rwc_top
    import rwc_pkg::*;
#(
    parameter int unsigned STRETCH_BASE = STRETCH_BASE_CYC,
    parameter int unsigned WDOG_DIV = WDOG_TICK_DIV
) (
    input wire logic i_sys_clk,
    input wire logic i_sys_rst,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic i_por_active,
    input wire logic i_ext_rst_n,
    input wire logic i_undervolt,
    input wire logic i_scan_rst,
    input wire logic [2:0] i_undervolt_level_fuse,
    input wire logic [1:0] i_startup_time_fuse,
    input wire logic [3:0] i_clock_select_fuse,
    input wire logic i_wdog_always_on_fuse,
    input wire logic i_wdog_restart,
    input wire logic i_wdog_irq_ack,
    input wire logic i_converter_en,
    output logic o_io_rst,
    output logic o_sys_rst,
    output logic o_wdog_irq,
    output logic o_bandgap_en
);
    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    logic [3:0] pin_s1_ff;        // First sync stage, read by stage two only
    logic [3:0] pin_s2_ff;        // Synced {scan, undervolt, pin low, por}
    logic [1:0] qual_ff;          // Filtered {undervolt, pin low}
    logic [8:0] filt_cnt_ff [2];  // Active time per filtered source
    logic [1:0] filt_in;
    logic por_s;
    logic scan_s;
    logic uv_en;
    logic hold;                   // Any source active
    logic stretch_act;
    logic sys_rst_ff;
    logic rst_regs;               // Block reset or internal reset
    rwc_wdctl_t ctl_ff;           // Stored watchdog control
    rwc_wdctl_t nxt_ctl;
    rwc_wdctl_t wd;               // Write data as control word
    rwc_wdctl_t rd_ctl;           // Control as software sees it
    rwc_rstflag_t flags_ff;
    rwc_rstflag_t nxt_flags;
    rwc_rstflag_t flag_set;
    logic [2:0] ce_cnt_ff;        // Cycles left in the change window
    logic [2:0] nxt_ce_cnt;
    logic win_open;
    logic comparator_bandgap_sel_ff;                // Comparator bandgap select
    logic bandgap_ff;
    logic wdog_pulse_ff;
    logic wdt_to;
    logic re_eff;
    logic ie_eff;
    logic irq_set;
    logic pulse_set;
    logic apb_wr;
    logic wr_ctl;
    logic wr_flags;
    logic wr_ref;
    logic open_seq;
    logic commit;
    logic hit;
    logic [31:0] rd_mux;
    logic [31:0] prdata_ff;
    logic [2:0] shift;

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    // Two stages; reset pin inverted ahead of the first stage
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            pin_s1_ff <= 4'h0;
            pin_s2_ff <= 4'h0;
        end else begin
            pin_s1_ff <= {i_scan_rst, i_undervolt, ~i_ext_rst_n, i_por_active};
            pin_s2_ff <= pin_s1_ff;
        end
    end

    assign por_s = pin_s2_ff[0];
    assign scan_s = pin_s2_ff[3];
    // Detector is off when the level fuse reads unprogrammed
    assign uv_en = (i_undervolt_level_fuse != UV_FUSE_OFF);
    assign filt_in = {pin_s2_ff[2] & uv_en, pin_s2_ff[1]};

    // ----------------------------------------
    // Minimum-duration filters
    // ----------------------------------------
    // Glitches shorter than the minimum never reach the reset merge
    for (genvar g = 0; g < 2; g++) begin : g_filt
        localparam logic [8:0] MIN = (g == 0) ? 9'(EXT_MIN_CYC - 1) : 9'(UV_MIN_CYC - 1);
        always_ff @(posedge i_sys_clk) begin
            if (i_sys_rst || !filt_in[g]) begin
                filt_cnt_ff[g] <= 9'h000;
                qual_ff[g] <= 1'b0;
            end else if (filt_cnt_ff[g] == MIN) begin
                qual_ff[g] <= 1'b1; // RL5 RL10
            end else begin
                filt_cnt_ff[g] <= filt_cnt_ff[g] + 9'h001;
            end
        end
    end

    // ----------------------------------------
    // Reset merge and stretch
    // ----------------------------------------
    assign hold = por_s | qual_ff[0] | qual_ff[1] | scan_s | wdog_pulse_ff; // RL4 RL7 RL8 RL9
    // Raw port reset: no clock needed, so short pin pulses may also show
    assign o_io_rst = i_sys_rst | i_por_active | ~i_ext_rst_n
        | (uv_en & i_undervolt) | i_scan_rst | wdog_pulse_ff; // RL2
    assign shift = {1'b0, i_startup_time_fuse} + {2'b00, |i_clock_select_fuse};

    rwc_stretch #(
        .BASE(STRETCH_BASE)
    ) u_stretch (
        .i_sys_clk(i_sys_clk),
        .i_sys_rst(i_sys_rst),
        .i_hold(hold),
        .i_shift(shift),
        .o_active(stretch_act)
    );

    // Core restarts from its vector when this falls
    always_ff @(posedge i_sys_clk) begin
        sys_rst_ff <= i_sys_rst | hold | stretch_act; // RL1 RL3 RL6
    end
    assign o_sys_rst = sys_rst_ff;
    assign rst_regs = i_sys_rst | sys_rst_ff;

    // ----------------------------------------
    // Watchdog mode and counter
    // ----------------------------------------
    assign re_eff = ctl_ff.reset_en | flags_ff.wdog | i_wdog_always_on_fuse; // RL19 RL23
    assign ie_eff = ctl_ff.irq_en & ~i_wdog_always_on_fuse; // RL19

    // Tick enable models the separate oscillator; a real part needs a crossing
    rwc_wdog #(
        .TICK_DIV(WDOG_DIV)
    ) u_wdog (
        .i_sys_clk(i_sys_clk),
        .i_sys_rst(rst_regs),
        .i_clear(i_wdog_restart), // RL14
        .i_run(re_eff | ie_eff),
        .i_sel({ctl_ff.presc_hi, ctl_ff.presc_lo}), // RL13 RL15
        .o_timeout(wdt_to)
    );

    // Interrupt unless combined mode already has its flag pending
    assign irq_set = wdt_to & ie_eff & ~(re_eff & ctl_ff.irq_flag); // RL16 RL18
    assign pulse_set = wdt_to & re_eff & ~(ie_eff & ~ctl_ff.irq_flag); // RL17 RL18

    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            wdog_pulse_ff <= 1'b0;
        end else begin
            wdog_pulse_ff <= pulse_set; // RL11
        end
    end
    assign o_wdog_irq = ctl_ff.irq_flag & ie_eff;

    // ----------------------------------------
    // APB decode
    // ----------------------------------------
    assign apb_wr = i_psel & i_penable & i_pwrite;
    assign wr_ctl = apb_wr & (i_paddr == OFS_WDOG_CTRL);
    assign wr_flags = apb_wr & (i_paddr == OFS_RST_FLAGS);
    assign wr_ref = apb_wr & (i_paddr == OFS_REF_CTRL);
    assign hit = (i_paddr == OFS_WDOG_CTRL) | (i_paddr == OFS_RST_FLAGS)
        | (i_paddr == OFS_REF_CTRL);
    assign wd = rwc_wdctl_t'(i_pwdata[7:0]);
    assign win_open = (ce_cnt_ff != 3'h0);
    assign open_seq = wr_ctl & wd.change_en & wd.reset_en; // RL20
    assign commit = wr_ctl & win_open & ~wd.change_en; // RL21

    // ----------------------------------------
    // Watchdog control next state
    // ----------------------------------------
    always_comb begin
        nxt_ctl = ctl_ff;
        nxt_ctl.change_en = 1'b0;
        if (commit) begin
            // A pending watchdog reset flag keeps the enable set through a commit
            nxt_ctl.reset_en = wd.reset_en | flags_ff.wdog; // RL21 RL23
            nxt_ctl.presc_hi = wd.presc_hi;
            nxt_ctl.presc_lo = wd.presc_lo;
        end else if (wr_ctl && wd.reset_en) begin
            nxt_ctl.reset_en = 1'b1; // Setting never needs the window
        end
        if (wr_ctl) begin
            nxt_ctl.irq_en = wd.irq_en;
        end else if (i_wdog_irq_ack && re_eff) begin
            nxt_ctl.irq_en = 1'b0; // Vector drops combined mode to reset mode
        end
        // Set beats both clears
        if (irq_set) begin
            nxt_ctl.irq_flag = 1'b1; // RL24
        end else if (i_wdog_irq_ack || (wr_ctl && wd.irq_flag)) begin
            nxt_ctl.irq_flag = 1'b0; // RL24
        end
    end

    // Window count: four on opening, shut by a commit or by running out
    assign nxt_ce_cnt = open_seq ? CE_WINDOW
        : commit ? 3'h0
        : win_open ? ce_cnt_ff - 3'h1 : 3'h0; // RL22

    always_ff @(posedge i_sys_clk) begin
        if (rst_regs) begin
            ctl_ff <= rwc_wdctl_t'(WDCTL_RST); // RL1
            ce_cnt_ff <= 3'h0;
            comparator_bandgap_sel_ff <= 1'b0;
        end else begin
            ctl_ff <= nxt_ctl;
            ce_cnt_ff <= nxt_ce_cnt;
            comparator_bandgap_sel_ff <= wr_ref ? i_pwdata[0] : comparator_bandgap_sel_ff;
        end
    end

    // ----------------------------------------
    // Reset source flags
    // ----------------------------------------
    // Power-on, a written zero and the block reset clear them; internal reset does not
    assign flag_set = {scan_s, wdog_pulse_ff, qual_ff[1], qual_ff[0], por_s};
    always_comb begin
        nxt_flags = flags_ff;
        if (wr_flags) begin
            nxt_flags = flags_ff & rwc_rstflag_t'(i_pwdata[4:0]);
        end
        if (por_s) begin
            nxt_flags = FLAGS_RST;
        end
        nxt_flags = nxt_flags | flag_set; // RL25
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            flags_ff <= rwc_rstflag_t'(FLAGS_RST);
        end else begin
            flags_ff <= nxt_flags;
        end
    end

    // ----------------------------------------
    // Bandgap enable
    // ----------------------------------------
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            bandgap_ff <= 1'b0;
        end else begin
            bandgap_ff <= uv_en | comparator_bandgap_sel_ff | i_converter_en; // RL12
        end
    end
    assign o_bandgap_en = bandgap_ff;

    // ----------------------------------------
    // APB read path
    // ----------------------------------------
    always_comb begin
        rd_ctl = ctl_ff;
        rd_ctl.change_en = win_open;
        rd_ctl.reset_en = re_eff; // RL23
        rd_ctl.irq_en = ie_eff;
    end
    assign rd_mux = (i_paddr == OFS_WDOG_CTRL) ? {24'h000000, rd_ctl}
        : (i_paddr == OFS_RST_FLAGS) ? {27'h0000000, flags_ff}
        : (i_paddr == OFS_REF_CTRL) ? {30'h00000000, bandgap_ff, comparator_bandgap_sel_ff}
        : 32'h00000000;

    // Read data caught in setup, so the access phase needs no wait
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            prdata_ff <= 32'h00000000;
        end else if (i_psel && !i_penable) begin
            prdata_ff <= rd_mux;
        end
    end
    assign o_prdata = prdata_ff;
    assign o_pready = 1'b1;
    assign o_pslverr = i_psel & i_penable & ~hit;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_sys_rst);

    sequence s_first_expiry;
        wdt_to && ie_eff && re_eff && !ctl_ff.irq_flag;
    endsequence
    sequence s_irq_not_reset;
        ctl_ff.irq_flag && !wdog_pulse_ff;
    endsequence

    a_wdrst_one_cycle: assert property (wdog_pulse_ff |=> !wdog_pulse_ff) // RL11
        else $error("watchdog reset pulse longer than one cycle");
    a_wdrst_stretch: assert property (wdog_pulse_ff |=> o_sys_rst [*3]) // RL11
        else $error("stretch did not follow watchdog pulse");
    a_hold_reset: assert property (hold |=> o_sys_rst) // RL3
        else $error("internal reset not asserted while source active");
    a_scan_hold: assert property (scan_s [*2] |-> o_sys_rst) // RL7
        else $error("scan reset bit did not hold reset");
    a_io_reset: assert property (i_scan_rst || i_por_active |-> o_io_rst) // RL2
        else $error("port reset missing while source active");
    a_ce_window: assert property ($rose(win_open) |-> ##[1:4] !win_open) // RL22
        else $error("change enable open beyond four cycles");
    a_presc_guard: assert property (wr_ctl && !win_open && !sys_rst_ff
        |=> $stable(ctl_ff.presc_lo) && $stable(ctl_ff.presc_hi)) // RL21
        else $error("prescaler changed outside window");
    a_rsten_lock: assert property (flags_ff.wdog |-> rd_ctl.reset_en) // RL23
        else $error("reset enable readable as clear with flag set");
    a_fuse_mode: assert property (i_wdog_always_on_fuse |-> re_eff && !ie_eff) // RL19
        else $error("always-on fuse did not force reset mode");
    a_irq_mode: assert property (wdt_to && ie_eff && !re_eff |=> ctl_ff.irq_flag) // RL16
        else $error("interrupt flag not set on expiry");
    a_reset_mode: assert property (wdt_to && re_eff && !ie_eff |=> wdog_pulse_ff) // RL17
        else $error("reset mode expiry gave no reset pulse");
    a_combined_mode: assert property (s_first_expiry |=> s_irq_not_reset) // RL18
        else $error("combined mode first expiry wrong");
    a_restart_clear: assert property (i_wdog_restart |=> !wdt_to) // RL14
        else $error("time-out despite restart");
    a_por_flag: assert property (por_s |=> flags_ff.por) // RL25
        else $error("power-on flag not set");
    a_bandgap_on: assert property (uv_en |=> o_bandgap_en) // RL12
        else $error("bandgap off with detector enabled");
endmodule
`default_nettype wire

// ==== rtl/rwc_pkg.sv ====
/*
 Shared constants and carrier types for the reset and watchdog controller.
 Assumes one system clock of 125 MHz; every time below is turned into cycles here.
*/
package rwc_pkg;
    // ----------------------------------------
    // Clock and timing
    // ----------------------------------------
    localparam int unsigned SYS_CLK_HZ = 125_000_000;
    localparam int unsigned CLK_PERIOD_NS = 8;
    // Least low time of the reset pin, rounded up to cycles
    localparam int unsigned EXT_MIN_PULSE_NS = 2500;
    localparam int unsigned EXT_MIN_CYC =
        (EXT_MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Least under-voltage time, rounded up to cycles
    localparam int unsigned UV_MIN_DURATION_NS = 2000;
    localparam int unsigned UV_MIN_CYC =
        (UV_MIN_DURATION_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Base reset stretch, scaled up by the start-up fuses
    localparam int unsigned STRETCH_BASE_US = 4;
    localparam int unsigned STRETCH_BASE_CYC =
        (STRETCH_BASE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Watchdog oscillator rate, as an enable from the system clock
    localparam int unsigned WDOG_OSC_HZ = 128_000;
    localparam int unsigned WDOG_TICK_DIV = SYS_CLK_HZ / WDOG_OSC_HZ;
    localparam int unsigned WDOG_BASE_TICKS = 2048;
    localparam logic [3:0] WDOG_SEL_MAX = 4'h9;
    // Cycles during which the change enable stays open
    localparam logic [2:0] CE_WINDOW = 3'h4;
    // Undervolt level fuse code meaning detector off
    localparam logic [2:0] UV_FUSE_OFF = 3'h7;

    // ----------------------------------------
    // Register offsets and reset values
    // ----------------------------------------
    localparam logic [11:0] OFS_RST_FLAGS = 12'h000;
    localparam logic [11:0] OFS_WDOG_CTRL = 12'h004;
    localparam logic [11:0] OFS_REF_CTRL = 12'h008;
    localparam logic [7:0] WDCTL_RST = 8'h00;
    localparam logic [4:0] FLAGS_RST = 5'h00;

    // Watchdog control word, bit 7 down to bit 0
    typedef struct packed {
        logic irq_flag;
        logic irq_en;
        logic presc_hi;
        logic change_en;
        logic reset_en;
        logic [2:0] presc_lo;
    } rwc_wdctl_t;

    // Reset source flags, bit 4 down to bit 0
    typedef struct packed {
        logic scan;
        logic wdog;
        logic undervolt_detector;
        logic ext;
        logic por;
    } rwc_rstflag_t;
endpackage

// ==== rtl/rwc_wdog.sv ====
/*
 Watchdog counter: a tick enable standing in for the 128 kHz oscillator and a
 tick counter that pulses on the selected time-out.
 Assumes the caller clears it on restart and on internal reset.
*/
`timescale 1ns/10ps
`default_nettype none
module rwc_wdog
    import rwc_pkg::*;
#(
    parameter int unsigned TICK_DIV = WDOG_TICK_DIV
) (
    input wire logic i_sys_clk,
    input wire logic i_sys_rst,
    input wire logic i_clear,
    input wire logic i_run,
    input wire logic [3:0] i_sel,
    output logic o_timeout
);
    logic [9:0] div_ff;      // Cycles within one oscillator period
    logic [20:0] cnt_ff;     // Oscillator ticks since restart or the last time-out
    logic [3:0] sel_c;       // Reserved codes act as the longest
    logic [20:0] limit;
    logic tick;

    assign sel_c = (i_sel > WDOG_SEL_MAX) ? WDOG_SEL_MAX : i_sel;
    assign limit = 21'(WDOG_BASE_TICKS) << sel_c;
    assign tick = (div_ff == 10'(TICK_DIV - 1));

    // ----------------------------------------
    // Tick divider and time-out count
    // ----------------------------------------
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst || i_clear || !i_run) begin
            div_ff <= 10'h000;
            cnt_ff <= 21'h000000;
            o_timeout <= 1'b0;
        end else begin
            o_timeout <= 1'b0;
            if (tick) begin
                div_ff <= 10'h000;
                // Wrap and pulse once per period
                if (cnt_ff == limit - 21'h000001) begin
                    cnt_ff <= 21'h000000;
                    o_timeout <= 1'b1;
                end else begin
                    cnt_ff <= cnt_ff + 21'h000001;
                end
            end else begin
                div_ff <= div_ff + 10'h001;
            end
        end
    end
endmodule
`default_nettype wire

// ==== rtl/rwc_stretch.sv ====
/*
 Reset stretch counter: reloads while any source holds reset and counts
 down once all are gone. Assumes a shift of at most four.
*/
`timescale 1ns/10ps
`default_nettype none
module rwc_stretch
    import rwc_pkg::*;
#(
    parameter int unsigned BASE = STRETCH_BASE_CYC
) (
    input wire logic i_sys_clk,
    input wire logic i_sys_rst,
    input wire logic i_hold,
    input wire logic [2:0] i_shift,
    output logic o_active
);
    logic [13:0] cnt_ff;   // Cycles of stretch still to run
    logic [13:0] load;

    assign load = 14'(BASE) << i_shift;
    assign o_active = (cnt_ff != 14'h0000);

    // ----------------------------------------
    // Reload while held, run down after
    // ----------------------------------------
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst || i_hold) begin
            cnt_ff <= load;
        end else if (o_active) begin
            cnt_ff <= cnt_ff - 14'h0001;
        end
    end
endmodule
`default_nettype wire

// ==== sim/rwc_top_tb_top.sv ====
/* Self-checking bench for the reset and watchdog controller top.
   Assumes rwc_pkg and rwc_top are compiled first; no partner model. */
`timescale 1ns/10ps
`default_nettype none
module rwc_top_tb_top;
    import rwc_pkg::*;
    // ----------------------------------------
    // Stimulus, observation and tallies
    // ----------------------------------------
    localparam int SB = 4; // Short stretch keeps runs brief
    logic clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
    logic por = 1'b0, ext_n = 1'b1, uv = 1'b0, scan = 1'b0;
    logic aon = 1'b0, wdr = 1'b0, ack = 1'b0, conv = 1'b0;
    logic [2:0] uvf = 3'h7; // Detector off at first
    logic [1:0] startup_time_fuse = 2'h0;
    logic [3:0] cks = 4'h0;
    logic [11:0] pa = 12'h000;
    logic [31:0] pwd = 32'h0, prd, rd;
    logic prdy, perr, er, io_rst, sys_rst, irq, bg, held;
    int fail_count = 0, n_compared = 0, cyc = 0, seed = 48, n, len;
    always #4 clk = ~clk;
    rwc_top #(.STRETCH_BASE(SB), .WDOG_DIV(2)) u_dut (.i_sys_clk(clk), .i_sys_rst(rst),
        .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(pa), .i_pwdata(pwd),
        .o_prdata(prd), .o_pready(prdy), .o_pslverr(perr), .i_por_active(por),
        .i_ext_rst_n(ext_n), .i_undervolt(uv), .i_scan_rst(scan),
        .i_undervolt_level_fuse(uvf), .i_startup_time_fuse(startup_time_fuse),
        .i_clock_select_fuse(cks), .i_wdog_always_on_fuse(aon), .i_wdog_restart(wdr),
        .i_wdog_irq_ack(ack), .i_converter_en(conv), .o_io_rst(io_rst),
        .o_sys_rst(sys_rst), .o_wdog_irq(irq), .o_bandgap_en(bg));
    // ----------------------------------------
    // Expectations and shared tasks
    // ----------------------------------------
    function automatic int stretch_cyc();
        return SB << (startup_time_fuse + (cks != 4'h0));
    endfunction
    function automatic int wdog_cyc(input int sel);
        return (2048 << sel) * 2; // Ticks times divider
    endfunction
    function automatic logic pick(input int w);
        return (w == 0) ? sys_rst : irq;
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic conclude();
        $display("Compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic cycles(input int c);
        repeat (c) @(posedge clk);
    endtask
    // One APB transfer; request held until pready seen
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        pa <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (prdy !== 1'b1);
        rd = prd;
        er = perr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        check(rd, e);
    endtask
    // Wait, bounded, for reset (0) or interrupt (1) to reach a level
    task automatic wait_on(input int w, input logic lvl, input int lim, output int k);
        k = 0;
        while (pick(w) !== lvl && k < lim) begin
            @(posedge clk);
            k++;
        end
    endtask
    // Source 0 power-on, 1 pin, 2 undervolt, other scan
    task automatic hit(input int k, input int c);
        for (int p = 1; p >= 0; p--) begin
            case (k)
                0: por <= p[0];
                1: ext_n <= ~p[0];
                2: uv <= p[0];
                default: scan <= p[0];
            endcase
            if (p == 1) cycles(c);
            held = sys_rst;
        end
        @(posedge clk);
    endtask
    task automatic restart();
        wdr <= 1'b1;
        @(posedge clk);
        wdr <= 1'b0;
    endtask
    // Hang guard: well above the longest expected run
    always @(posedge clk) begin
        cyc++;
        if (cyc == 60000) begin
            fail_count++;
            conclude();
        end
    end
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        cycles(2);
        rst <= 1'b0;
        wait_on(0, 1'b0, 40, n);
        check(sys_rst, 1'b0);
        rd_chk(OFS_RST_FLAGS, {27'h0, FLAGS_RST});
        rd_chk(OFS_WDOG_CTRL, {24'h0, WDCTL_RST});
        apb(1'b0, 12'hFFC, 32'h0);
        check(er, 1'b1);
        check(rd, 32'h0);
        check(prdy, 1'b1);
        // Nonzero fuses lengthen every stretch that follows
        startup_time_fuse <= 2'h1;
        cks <= 4'h2;
        // Port reset follows the scan bit with no edge
        @(posedge clk);
        scan <= 1'b1;
        #1 check(io_rst, 1'b1);
        hit(3, 20);
        check(held, 1'b1);
        wait_on(0, 1'b0, 40, n);
        check(n >= stretch_cyc() && n <= stretch_cyc() + 6, 1'b1);
        rd_chk(OFS_RST_FLAGS, 32'h10);
        hit(0, 10);
        check(held, 1'b1);
        wait_on(0, 1'b0, 40, n);
        check(n >= stretch_cyc(), 1'b1);
        rd_chk(OFS_RST_FLAGS, 32'h01);
        apb(1'b1, OFS_RST_FLAGS, 32'h0);
        // Reference on for each cause alone
        for (int i = 0; i < 4; i++) begin
            conv <= i[0];
            apb(1'b1, OFS_REF_CTRL, {31'h0, i[1]});
            cycles(2);
            check(bg, i != 0);
        end
        rd_chk(OFS_REF_CTRL, 32'h3);
        conv <= 1'b0;
        apb(1'b1, OFS_REF_CTRL, 32'h0);
        uvf <= 3'h4;
        cycles(3);
        check(bg, 1'b1);
        // Short glitch ignored, long low resets, then stretch
        for (int k = 1; k < 3; k++) begin
            len = 20 + {$random(seed)} % 200;
            hit(k, len);
            cycles(6);
            check(sys_rst, 1'b0);
            hit(k, (k == 1 ? EXT_MIN_CYC : UV_MIN_CYC) + 10);
            check(held, 1'b1);
            wait_on(0, 1'b0, 40, n);
            check(n >= stretch_cyc(), 1'b1);
            rd_chk(OFS_RST_FLAGS, 32'h1 << k);
            apb(1'b1, OFS_RST_FLAGS, 32'h0);
        end
        // Guarded fields: late commit refused, early one taken
        apb(1'b1, OFS_WDOG_CTRL, 32'h58);
        rd_chk(OFS_WDOG_CTRL, 32'h58);
        cycles(5);
        rd_chk(OFS_WDOG_CTRL, 32'h48);
        apb(1'b1, OFS_WDOG_CTRL, 32'h45);
        rd_chk(OFS_WDOG_CTRL, 32'h48);
        apb(1'b1, OFS_WDOG_CTRL, 32'h58);
        apb(1'b1, OFS_WDOG_CTRL, 32'h40);
        rd_chk(OFS_WDOG_CTRL, 32'h40);
        // Interrupt mode: restarts hold it off, expiry raises it
        repeat (3) begin
            restart();
            cycles(3000);
        end
        check(irq, 1'b0);
        restart();
        wait_on(1, 1'b1, 5000, n);
        check(n >= wdog_cyc(0) - 6 && n <= wdog_cyc(0) + 6, 1'b1);
        ack <= 1'b1;
        @(posedge clk);
        ack <= 1'b0;
        cycles(2);
        check(irq, 1'b0);
        wait_on(1, 1'b1, 5000, n);
        apb(1'b1, OFS_WDOG_CTRL, 32'hC0);
        cycles(1);
        check(irq, 1'b0);
        // Combined mode at the next prescale step
        apb(1'b1, OFS_WDOG_CTRL, 32'h58);
        apb(1'b1, OFS_WDOG_CTRL, 32'h49);
        restart();
        wait_on(1, 1'b1, 9000, n);
        check(n >= wdog_cyc(1) - 6 && n <= wdog_cyc(1) + 6, 1'b1);
        check(sys_rst, 1'b0);
        wait_on(0, 1'b1, 9000, n);
        check(n >= wdog_cyc(1) - 6 && n <= wdog_cyc(1) + 6, 1'b1);
        wait_on(0, 1'b0, 40, n);
        check(n >= stretch_cyc() && n <= stretch_cyc() + 4, 1'b1);
        rd_chk(OFS_RST_FLAGS, 32'h08);
        apb(1'b1, OFS_WDOG_CTRL, 32'h18);
        apb(1'b1, OFS_WDOG_CTRL, 32'h00);
        rd_chk(OFS_WDOG_CTRL, 32'h08);
        apb(1'b1, OFS_RST_FLAGS, 32'h0);
        rd_chk(OFS_WDOG_CTRL, 32'h08);
        apb(1'b1, OFS_WDOG_CTRL, 32'h18);
        apb(1'b1, OFS_WDOG_CTRL, 32'h00);
        rd_chk(OFS_WDOG_CTRL, 32'h00);
        // Fuse locks the mode bits
        aon <= 1'b1;
        cycles(2);
        apb(1'b1, OFS_WDOG_CTRL, 32'h40);
        rd_chk(OFS_WDOG_CTRL, 32'h08);
        conclude();
    end
endmodule
`default_nettype wire
